// ===== rtl/skip_table_xor_pkg.sv
// shared constants, opcodes and states of the skip/table/xor execution slice
package skip_table_xor_pkg;

  localparam int DATA_W = 8;
  localparam int NIBBLE_W = 4;
  localparam int BIT_IDX_W = 3;
  localparam int DMEM_ADDR_W = 8;
  localparam int PAGE_W = 4;
  localparam int PTR_W = 8;
  localparam int PROG_ADDR_W = PAGE_W + PTR_W;
  localparam int PROG_WORD_W = 15;

  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [DATA_W-1:0] WORK_RESET = 8'h00;
  localparam logic [PAGE_W-1:0] LAST_PAGE = 4'hF;
  localparam logic ZERO_FLAG_RESET = 1'b0;

  // ---------------------------------------------------------------
  // opcodes of this slice
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NIBBLE_SWAP_TO_WORKING,
    OP_SKIP_IF_ZERO,
    OP_COPY_AND_SKIP_IF_ZERO,
    OP_SKIP_IF_BIT_ZERO,
    OP_TABLE_READ_CURRENT_PAGE,
    OP_TABLE_READ_LAST_PAGE,
    OP_EXCLUSIVE_OR_TO_WORKING,
    OP_EXCLUSIVE_OR_TO_MEMORY,
    OP_EXCLUSIVE_OR_IMMEDIATE
  } opcode_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_MEM_WAIT,
    ST_MEM_DATA,
    ST_PROG_WAIT,
    ST_PROG_DATA,
    ST_DUMMY
  } exec_state_t;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic is_zero(input logic [DATA_W-1:0] value);
    return value == ZERO_BYTE;
  endfunction

endpackage

// ===== rtl/xor_zero_unit.sv
// bitwise exclusive-or with zero detect
`timescale 1ns/1ps
module xor_zero_unit
  import skip_table_xor_pkg::*;
(
  input wire logic [DATA_W-1:0] lhs, // working register value
  input wire logic [DATA_W-1:0] rhs, // memory byte or immediate
  output logic [DATA_W-1:0] result, // exclusive-or result
  output logic zero // result is zero
);

  always_comb
  begin
    result = lhs ^ rhs;
    zero = is_zero(lhs ^ rhs);
  end

endmodule

// ===== rtl/skip_condition.sv
// decides whether a skip instruction skips
`timescale 1ns/1ps
module skip_condition
  import skip_table_xor_pkg::*;
(
  input wire opcode_t op, // instruction being executed
  input wire logic [DATA_W-1:0] mem_byte, // addressed memory byte
  input wire logic [BIT_IDX_W-1:0] bit_idx, // selected bit
  output logic skip // following instruction is skipped
);

  always_comb
  begin
    case (op)
      OP_SKIP_IF_ZERO: skip = is_zero(mem_byte);
      OP_COPY_AND_SKIP_IF_ZERO: skip = is_zero(mem_byte);
      OP_SKIP_IF_BIT_ZERO: skip = ~mem_byte[bit_idx];
      default: skip = 1'b0;
    endcase
  end

endmodule

// ===== rtl/skip_table_xor_exec.sv
// execution unit for swap, zero-skip, table read and xor instructions
//
// Function
// - swap to working: low nibble from mem 7..4, high from 3..0; no flags
// - skip-if-zero skips next instruction when memory byte is zero; no flags
// - a taken skip inserts one dummy cycle, making four cycles instead of three
// - copy-and-skip loads working register, skips when that byte is zero
// - bit-skip skips when selected bit of memory byte is zero; no flags
// - current-page table read fetches current page word at table pointer
// - last-page table read fetches last page word at table pointer
// - table read: low byte to memory, high byte to table high register
// - xor to working: working ^ memory into working, zero flag only
// - xor to memory: working ^ memory into memory, zero flag only
// - immediate xor: working ^ immediate into working, zero flag only
`timescale 1ns/1ps
module skip_table_xor_exec
  import skip_table_xor_pkg::*;
#(
  parameter int PROG_W = PROG_WORD_W
)
(
  input wire logic clk_sys, // core instruction clock
  input wire logic srst, // synchronous reset, active high
  input wire logic ce, // clock enable, freezes all state when low, srst still resets
  input wire logic issue_valid, // instruction offered for execution
  input wire opcode_t issue_op, // instruction opcode
  input wire logic [DMEM_ADDR_W-1:0] issue_addr, // data memory operand address
  input wire logic [BIT_IDX_W-1:0] issue_bit, // bit index for bit skip
  input wire logic [DATA_W-1:0] issue_imm, // immediate operand
  input wire logic [PTR_W-1:0] table_pointer, // table pointer register value
  input wire logic [PAGE_W-1:0] current_page, // program counter page
  input wire logic [DATA_W-1:0] dmem_rdata, // data memory read data
  input wire logic [PROG_W-1:0] pmem_rdata, // program memory read word
  output logic busy, // instruction in progress, issue refused
  output logic done, // instruction retired, pulse
  output logic skip_taken, // discard next fetched instruction, pulse
  output logic dmem_rd, // data memory read strobe
  output logic dmem_wr, // data memory write strobe
  output logic [DMEM_ADDR_W-1:0] dmem_addr, // data memory address
  output logic [DATA_W-1:0] dmem_wdata, // data memory write data
  output logic pmem_rd, // program memory read strobe
  output logic [PROG_ADDR_W-1:0] pmem_addr, // program memory address
  output logic [DATA_W-1:0] work, // working register
  output logic zero_flag, // zero flag
  output logic [PROG_W-DATA_W-1:0] table_high_byte // table high-byte register
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    exec_state_t st;
    opcode_t op;
    logic [BIT_IDX_W-1:0] bit_idx;
    logic busy;
    logic done;
    logic skip_taken;
    logic dmem_rd;
    logic dmem_wr;
    logic [DMEM_ADDR_W-1:0] dmem_addr;
    logic [DATA_W-1:0] dmem_wdata;
    logic pmem_rd;
    logic [PROG_ADDR_W-1:0] pmem_addr;
    logic [DATA_W-1:0] work;
    logic zero_flag;
    logic [PROG_W-DATA_W-1:0] table_high;
  } regs_t;

  regs_t r_q;
  regs_t r_d;

  logic [DATA_W-1:0] xor_lhs_rhs;
  logic [DATA_W-1:0] xor_rhs;
  logic [DATA_W-1:0] xor_result;
  logic xor_zero;
  logic skip_now;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // program word address, page above the table pointer
  function automatic logic [PROG_ADDR_W-1:0] table_word_addr(
    input logic [PAGE_W-1:0] page,
    input logic [PTR_W-1:0] ptr
  );
    return {page, ptr};
  endfunction

  // low and high nibble exchanged
  function automatic logic [DATA_W-1:0] swap_nibbles(input logic [DATA_W-1:0] value);
    return {value[NIBBLE_W-1:0], value[DATA_W-1:NIBBLE_W]};
  endfunction

  // instructions whose operand comes from data memory
  function automatic logic reads_data_memory(input opcode_t op);
    case (op)
      OP_NIBBLE_SWAP_TO_WORKING,
      OP_SKIP_IF_ZERO,
      OP_COPY_AND_SKIP_IF_ZERO,
      OP_SKIP_IF_BIT_ZERO,
      OP_EXCLUSIVE_OR_TO_WORKING,
      OP_EXCLUSIVE_OR_TO_MEMORY: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // register contents after reset
  function automatic regs_t reset_regs();
    regs_t v;
    v = '0;
    v.st = ST_IDLE;
    v.op = OP_NIBBLE_SWAP_TO_WORKING;
    v.work = WORK_RESET;
    v.zero_flag = ZERO_FLAG_RESET;
    return v;
  endfunction

  // ---------------------------------------------------------------
  // datapath pieces
  // ---------------------------------------------------------------
  assign xor_lhs_rhs = r_q.work;

  // immediate form is resolved at issue, memory forms once the byte is back
  always_comb
  begin
    if (r_q.st == ST_IDLE)
    begin
      xor_rhs = issue_imm;
    end
    else
    begin
      xor_rhs = dmem_rdata;
    end
  end

  xor_zero_unit u_xor (
    .lhs(xor_lhs_rhs),
    .rhs(xor_rhs),
    .result(xor_result),
    .zero(xor_zero)
  );

  skip_condition u_skip (
    .op(r_q.op),
    .mem_byte(dmem_rdata),
    .bit_idx(r_q.bit_idx),
    .skip(skip_now)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    r_d = r_q;
    r_d.done = 1'b0;
    r_d.skip_taken = 1'b0;
    r_d.dmem_rd = 1'b0;
    r_d.dmem_wr = 1'b0;
    r_d.pmem_rd = 1'b0;
    case (r_q.st)
      ST_IDLE:
      begin
        if (issue_valid)
        begin
          r_d.op = issue_op;
          r_d.bit_idx = issue_bit;
          r_d.dmem_addr = issue_addr;
          case (issue_op)
            OP_EXCLUSIVE_OR_IMMEDIATE:
            begin
              r_d.work = xor_result;
              r_d.zero_flag = xor_zero;
              r_d.done = 1'b1;
            end
            OP_TABLE_READ_CURRENT_PAGE:
            begin
              r_d.pmem_addr = table_word_addr(current_page, table_pointer);
              r_d.pmem_rd = 1'b1;
              r_d.st = ST_PROG_WAIT;
            end
            OP_TABLE_READ_LAST_PAGE:
            begin
              r_d.pmem_addr = table_word_addr(LAST_PAGE, table_pointer);
              r_d.pmem_rd = 1'b1;
              r_d.st = ST_PROG_WAIT;
            end
            default:
            begin
              if (reads_data_memory(issue_op))
              begin
                r_d.dmem_rd = 1'b1;
                r_d.st = ST_MEM_WAIT;
              end
              else
              begin
                // code outside this slice: retire at once, only op, bit index and dmem_addr are latched
                r_d.done = 1'b1;
              end
            end
          endcase
        end
      end
      ST_MEM_WAIT:
      begin
        // memory answers one cycle after the read strobe
        r_d.st = ST_MEM_DATA;
      end
      ST_MEM_DATA:
      begin
        r_d.st = ST_IDLE;
        r_d.done = 1'b1;
        case (r_q.op)
          OP_NIBBLE_SWAP_TO_WORKING:
          begin
            r_d.work = swap_nibbles(dmem_rdata);
          end
          OP_COPY_AND_SKIP_IF_ZERO:
          begin
            r_d.work = dmem_rdata;
          end
          OP_SKIP_IF_ZERO,
          OP_SKIP_IF_BIT_ZERO:
          begin
            r_d.work = r_q.work;
          end
          OP_EXCLUSIVE_OR_TO_WORKING:
          begin
            r_d.work = xor_result;
            r_d.zero_flag = xor_zero;
          end
          OP_EXCLUSIVE_OR_TO_MEMORY:
          begin
            r_d.dmem_wr = 1'b1;
            r_d.dmem_wdata = xor_result;
            r_d.zero_flag = xor_zero;
          end
          default:
          begin
            r_d.work = r_q.work;
          end
        endcase
        if (skip_now)
        begin
          r_d.st = ST_DUMMY;
          r_d.done = 1'b0;
        end
      end
      ST_PROG_WAIT:
      begin
        // program word arrives one cycle after the read strobe
        r_d.st = ST_PROG_DATA;
      end
      ST_PROG_DATA:
      begin
        r_d.dmem_wr = 1'b1;
        r_d.dmem_wdata = pmem_rdata[DATA_W-1:0];
        r_d.table_high = pmem_rdata[PROG_W-1:DATA_W];
        r_d.done = 1'b1;
        r_d.st = ST_IDLE;
      end
      ST_DUMMY:
      begin
        // no architectural change, only retire and flag the skip
        r_d.skip_taken = 1'b1;
        r_d.done = 1'b1;
        r_d.st = ST_IDLE;
      end
      default:
      begin
        r_d.st = ST_IDLE;
      end
    endcase
    r_d.busy = (r_d.st != ST_IDLE);
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      r_q <= reset_regs();
    end
    else if (ce)
    begin
      r_q <= r_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign busy = r_q.busy;
  assign done = r_q.done;
  assign skip_taken = r_q.skip_taken;
  assign dmem_rd = r_q.dmem_rd;
  assign dmem_wr = r_q.dmem_wr;
  assign dmem_addr = r_q.dmem_addr;
  assign dmem_wdata = r_q.dmem_wdata;
  assign pmem_rd = r_q.pmem_rd;
  assign pmem_addr = r_q.pmem_addr;
  assign work = r_q.work;
  assign zero_flag = r_q.zero_flag;
  assign table_high_byte = r_q.table_high;

endmodule

// ===== dv/skip_table_xor_exec_sva.sv
// port assertions for the execution slice
`timescale 1ns/1ps
module skip_table_xor_exec_sva
  import skip_table_xor_pkg::*;
(
  input wire logic clk_sys, // clock
  input wire logic srst, // reset
  input wire logic ce, // enable
  input wire logic issue_valid, // offer
  input wire opcode_t issue_op, // opcode
  input wire logic [DMEM_ADDR_W-1:0] issue_addr, // operand
  input wire logic [PAGE_W-1:0] current_page, // page
  input wire logic busy, // busy
  input wire logic done, // retire
  input wire logic skip_taken, // skip
  input wire logic dmem_rd, // read
  input wire logic dmem_wr, // write
  input wire logic [DMEM_ADDR_W-1:0] dmem_addr, // address
  input wire logic [DATA_W-1:0] dmem_wdata, // wdata
  input wire logic pmem_rd, // prog read
  input wire logic [PROG_ADDR_W-1:0] pmem_addr, // prog address
  input wire logic [DATA_W-1:0] work, // working
  input wire logic zero_flag // zero
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  logic take;
  assign take = ce && issue_valid && !busy && !srst;
  a_imm_done: assert property (take && issue_op == OP_EXCLUSIVE_OR_IMMEDIATE |=>
    done && zero_flag == (work == 8'h00)) else $error("immediate xor result");
  a_mem_read: assert property (take && issue_op inside {OP_NIBBLE_SWAP_TO_WORKING,
    OP_SKIP_IF_ZERO, OP_COPY_AND_SKIP_IF_ZERO, OP_SKIP_IF_BIT_ZERO,
    OP_EXCLUSIVE_OR_TO_WORKING, OP_EXCLUSIVE_OR_TO_MEMORY} |=> dmem_rd &&
    dmem_addr == $past(issue_addr)) else $error("operand read");
  a_last_page: assert property (take && issue_op == OP_TABLE_READ_LAST_PAGE |=>
    pmem_rd && pmem_addr[11:8] == LAST_PAGE) else $error("last page");
  a_cur_page: assert property (take && issue_op == OP_TABLE_READ_CURRENT_PAGE |=>
    pmem_rd && pmem_addr[11:8] == $past(current_page)) else $error("current page");
  a_table_write: assert property (take && issue_op inside {OP_TABLE_READ_CURRENT_PAGE,
    OP_TABLE_READ_LAST_PAGE} |-> ##3 dmem_wr && done) else $error("table write");
  a_xor_work: assert property (take && issue_op == OP_EXCLUSIVE_OR_TO_WORKING |->
    ##3 done && zero_flag == (work == 8'h00)) else $error("xor to working");
  a_xor_mem: assert property (take && issue_op == OP_EXCLUSIVE_OR_TO_MEMORY |->
    ##3 dmem_wr && zero_flag == (dmem_wdata == 8'h00)) else $error("xor to memory");
  a_swap_flag: assert property (take && issue_op == OP_NIBBLE_SWAP_TO_WORKING |->
    ##3 done && $stable(zero_flag)) else $error("swap flags");
  a_dummy_quiet: assert property (skip_taken |->
    done && !dmem_wr && $stable(zero_flag)) else $error("dummy cycle");
  c_skip: cover property (skip_taken);
  c_write: cover property (dmem_wr && done);
  c_table: cover property (pmem_rd);
endmodule

bind skip_table_xor_exec skip_table_xor_exec_sva u_sva (.clk_sys, .srst, .ce, .issue_valid,
  .issue_op, .issue_addr, .current_page, .busy, .done, .skip_taken, .dmem_rd, .dmem_wr,
  .dmem_addr, .dmem_wdata, .pmem_rd, .pmem_addr, .work, .zero_flag);

// ===== dv/mem_model.sv
// data and program memory facing the execution slice
`timescale 1ns/1ps
module mem_model
  import skip_table_xor_pkg::*;
(
  input wire logic clk_sys, // clock
  input wire logic dmem_rd, // read strobe
  input wire logic dmem_wr, // write strobe
  input wire logic [DMEM_ADDR_W-1:0] dmem_addr, // address
  input wire logic [DATA_W-1:0] dmem_wdata, // write data
  input wire logic pmem_rd, // prog strobe
  input wire logic [PROG_ADDR_W-1:0] pmem_addr, // prog address
  output logic [DATA_W-1:0] dmem_rdata, // read data
  output logic [PROG_WORD_W-1:0] pmem_rdata // prog word
);
  logic [DATA_W-1:0] dm [256];
  initial
  begin
    dmem_rdata = 8'h00;
    pmem_rdata = 15'h0000;
  end
  // data valid one cycle after the strobe, toggling otherwise
  always @(posedge clk_sys)
  begin
    if (dmem_wr)
      dm[dmem_addr] <= dmem_wdata;
    dmem_rdata <= dmem_rd ? dm[dmem_addr] : ~dmem_rdata;
    pmem_rdata <= pmem_rd ? {pmem_addr[11:5], pmem_addr[7:0] ^ 8'h3C} : ~pmem_rdata;
  end
endmodule

// ===== dv/skip_table_xor_exec_bench.sv
// self-checking bench for the execution slice
`timescale 1ns/1ps
module skip_table_xor_exec_bench;
  import skip_table_xor_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic issue_valid = 1'b0;
  opcode_t issue_op = OP_EXCLUSIVE_OR_IMMEDIATE;
  logic [7:0] issue_addr = 8'h00, issue_imm = 8'h00, table_pointer = 8'h00;
  logic [2:0] issue_bit = 3'h0;
  logic [3:0] current_page = 4'h0;
  logic [7:0] dmem_rdata, dmem_addr, dmem_wdata, work, w_m;
  logic [14:0] pmem_rdata;
  logic [11:0] pmem_addr;
  logic [6:0] table_high_byte, th_m;
  logic busy, done, skip_taken, dmem_rd, dmem_wr, pmem_rd, zero_flag, z_m;
  int num_errors = 0;
  int compares = 0;

  skip_table_xor_exec u_dut (.clk_sys, .srst, .ce, .issue_valid, .issue_op, .issue_addr,
    .issue_bit, .issue_imm, .table_pointer, .current_page, .dmem_rdata, .pmem_rdata, .busy,
    .done, .skip_taken, .dmem_rd, .dmem_wr, .dmem_addr, .dmem_wdata, .pmem_rd, .pmem_addr,
    .work, .zero_flag, .table_high_byte);
  mem_model u_mem (.clk_sys, .dmem_rd, .dmem_wr, .dmem_addr, .dmem_wdata, .pmem_rd,
    .pmem_addr, .dmem_rdata, .pmem_rdata);

  initial
    forever #4 clk_sys = ~clk_sys;

  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string s);
    compares++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, s, g, e);
    end
  endtask

  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // one instruction against the behavioural model
  task automatic run(input opcode_t op);
    logic [7:0] a, m, e_m;
    logic [14:0] pw;
    logic sk;
    int n;
    @(negedge clk_sys);
    a = 8'($urandom);
    m = ($urandom_range(0, 3) == 0) ? 8'h00 : 8'($urandom);
    u_mem.dm[a] = m;
    issue_op = op;
    issue_addr = a;
    issue_bit = 3'($urandom);
    issue_imm = 8'($urandom);
    table_pointer = 8'($urandom);
    current_page = 4'($urandom);
    issue_valid = 1'b1;
    pw = {(op == OP_TABLE_READ_LAST_PAGE) ? LAST_PAGE : current_page, table_pointer[7:5],
      table_pointer ^ 8'h3C};
    e_m = m;
    sk = (op inside {OP_SKIP_IF_ZERO, OP_COPY_AND_SKIP_IF_ZERO} && m == 8'h00) ||
      (op == OP_SKIP_IF_BIT_ZERO && !m[issue_bit]);
    case (op)
      OP_NIBBLE_SWAP_TO_WORKING: w_m = {m[3:0], m[7:4]};
      OP_COPY_AND_SKIP_IF_ZERO: w_m = m;
      OP_TABLE_READ_CURRENT_PAGE, OP_TABLE_READ_LAST_PAGE:
      begin
        e_m = pw[7:0];
        th_m = pw[14:8];
      end
      OP_EXCLUSIVE_OR_TO_WORKING: w_m = w_m ^ m;
      OP_EXCLUSIVE_OR_TO_MEMORY: e_m = w_m ^ m;
      OP_EXCLUSIVE_OR_IMMEDIATE: w_m = w_m ^ issue_imm;
      default: e_m = m;
    endcase
    if (op inside {OP_EXCLUSIVE_OR_TO_WORKING, OP_EXCLUSIVE_OR_IMMEDIATE})
      z_m = (w_m == 8'h00);
    if (op == OP_EXCLUSIVE_OR_TO_MEMORY)
      z_m = (e_m == 8'h00);
    @(negedge clk_sys);
    issue_valid = 1'b0;
    n = 1;
    while (done !== 1'b1 && n < 20)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk(8'(n), (op >= OP_EXCLUSIVE_OR_IMMEDIATE) ? 8'h01 : sk ? 8'h04 : 8'h03, "cycles");
    chk({7'h00, busy}, 8'h00, "busy");
    chk({7'h00, skip_taken}, {7'h00, sk}, "skip");
    chk(work, w_m, "work");
    chk({7'h00, zero_flag}, {7'h00, z_m}, "zero");
    chk({1'b0, table_high_byte}, {1'b0, th_m}, "high");
    @(negedge clk_sys);
    chk(u_mem.dm[a], e_m, "memory");
  endtask

  initial
  begin
    void'($urandom(32'hF7DEEF16));
    w_m = 8'h00;
    z_m = 1'b0;
    th_m = 7'h00;
    repeat (10) @(negedge clk_sys);
    srst = 1'b0;
    chk(work, 8'h00, "reset work");
    ce = 1'b0;
    issue_op = OP_EXCLUSIVE_OR_IMMEDIATE;
    issue_imm = 8'h5A;
    issue_valid = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk({7'h00, done}, 8'h00, "frozen done");
    chk(work, 8'h00, "frozen work");
    issue_valid = 1'b0;
    ce = 1'b1;
    for (int i = 0; i < 270; i++)
    begin
      run(opcode_t'(i % 10));
      if (i % 10 == 9)
        $display("round %0d complete", i / 10);
    end
    finish_test();
  end

  initial
  begin
    #40000;
    num_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test();
  end
endmodule
